// [hw/cpu_regs.vh]
// constants for the general register file and result word pair
// Notes on behaviour
// RULE_01 - thirty-two general registers of 32 bits, selected by a 5-bit number.
// RULE_02 - register zero always reads zero; writes to it are dropped.
// RULE_03 - link writes go to register 31 without naming it; else ordinary.
// RULE_04 - separate 32-bit high and low result words for multiply and divide.
// RULE_05 - multiply puts product upper half in high word, lower half in low.
// RULE_06 - divide puts quotient in low word and remainder in high word.
// RULE_07 - multiply-add and multiply-subtract combine prior pair with new product.
// RULE_08 - after each accumulate the pair holds the running accumulated result.
// RULE_09 - program counter is never a numbered register; reachable only as operand.
// RULE_10 - three-register word fields: 31-26, 25-21, 20-16, 15-11, 10-6, 5-0.
// RULE_11 - compact codes 0,1 select 16,17; 2..7 direct; stack 29, return 31.
// RULE_12 - compact mode uses register 24 implicitly as condition register.
// RULE_13 - compact pc-relative operations can read the program counter as operand.
// RULE_14 - two reads and one write per clock; same-cycle write is bypassed.
// RULE_15 - general registers are not cleared by reset; undefined until written.
`ifndef CPU_REGS_VH
`define CPU_REGS_VH

`define DATA_W 32
`define REG_NUM_W 5
`define ZERO_REG 5'd0
`define LINK_REG 5'd31
`define STACK_REG 5'd29
`define COND_REG 5'd24
`define COMPACT_LOW_BASE 5'd16

// instruction field positions
`define OPCODE_HI 31
`define OPCODE_LO 26
`define FIRST_SRC_HI 25
`define FIRST_SRC_LO 21
`define SECOND_SRC_HI 20
`define SECOND_SRC_LO 16
`define DEST_HI 15
`define DEST_LO 11
`define SHAMT_HI 10
`define SHAMT_LO 6
`define FUNCT_HI 5
`define FUNCT_LO 0

// operand select modes
`define SEL_FULL 3'h0
`define SEL_COMPACT 3'h1
`define SEL_COND 3'h2
`define SEL_STACK 3'h3
`define SEL_RETURN 3'h4
`define SEL_PC 3'h5

// multiply-divide operations
`define MDU_NONE 3'h0
`define MDU_MUL 3'h1
`define MDU_DIV 3'h2
`define MDU_MADD 3'h3
`define MDU_MSUB 3'h4
`define MDU_SET_HIGH 3'h5
`define MDU_SET_LOW 3'h6

`define RESET_WORD 32'h00000000

`endif

// [hw/operand_select.v]
// maps a register selection mode to a full register number
`timescale 1ns/10ps
`default_nettype none
`include "cpu_regs.vh"
module operand_select (
	// selection
	input wire [2:0] mode,
	input wire [4:0] full_index,
	input wire [2:0] compact_code,
	// result
	output reg [4:0] reg_num,
	output reg use_pc
);
	always @* begin
		reg_num = `ZERO_REG;
		use_pc = 1'b0;
		case (mode)
			`SEL_FULL: begin
				reg_num = full_index;
			end
			`SEL_COMPACT: begin
				if (compact_code[2:1] == 2'b00) begin
					reg_num = `COMPACT_LOW_BASE | {4'h0, compact_code[0]}; // [RULE_11]
				end else begin
					reg_num = {2'b00, compact_code}; // [RULE_11]
				end
			end
			`SEL_COND: begin
				reg_num = `COND_REG; // [RULE_12]
			end
			`SEL_STACK: begin
				reg_num = `STACK_REG; // [RULE_11]
			end
			`SEL_RETURN: begin
				reg_num = `LINK_REG; // [RULE_11]
			end
			`SEL_PC: begin
				use_pc = 1'b1; // [RULE_13]
			end
			default: begin
				reg_num = full_index;
			end
		endcase
	end
endmodule
`default_nettype wire

// [hw/cpu_gpr_hilo_register_file.v]
// general registers, result word pair and instruction field decode
`timescale 1ns/10ps
`default_nettype none
`include "cpu_regs.vh"
module cpu_gpr_hilo_register_file (
	// clock and reset
	input wire CLK,
	input wire RST_N,
	// instruction word decode
	input wire [31:0] INSTR_WORD,
	output reg [5:0] OPCODE,
	output reg [4:0] FIRST_SOURCE_FIELD,
	output reg [4:0] SECOND_SOURCE_FIELD,
	output reg [4:0] DEST_FIELD,
	output reg [4:0] SHIFT_AMOUNT_FIELD,
	output reg [5:0] FUNCTION_FIELD,
	// program counter for pc-relative operands
	input wire [31:0] PC_VALUE,
	// read port a
	input wire [2:0] READ_A_MODE,
	input wire [4:0] READ_A_INDEX,
	input wire [2:0] READ_A_CODE,
	output reg [31:0] READ_A_DATA,
	// read port b
	input wire [2:0] READ_B_MODE,
	input wire [4:0] READ_B_INDEX,
	input wire [2:0] READ_B_CODE,
	output reg [31:0] READ_B_DATA,
	// write port
	input wire WRITE_EN,
	input wire [2:0] WRITE_MODE,
	input wire [4:0] WRITE_INDEX,
	input wire [2:0] WRITE_CODE,
	input wire [31:0] WRITE_DATA,
	// multiply-divide unit
	input wire [2:0] MDU_OP,
	input wire MDU_UNSIGNED,
	input wire [31:0] MDU_A,
	input wire [31:0] MDU_B,
	output reg [31:0] RESULT_HIGH_WORD,
	output reg [31:0] RESULT_LOW_WORD
);
	// entry zero is not stored; it reads as a constant
	reg [31:0] general_reg [1:31];
	wire [4:0] read_a_num;
	wire [4:0] read_b_num;
	wire [4:0] write_num_sel;
	wire read_a_pc;
	wire read_b_pc;
	wire write_pc;
	wire [4:0] write_num;
	wire write_ok;
	reg [31:0] next_read_a;
	reg [31:0] next_read_b;

	// multiply-divide datapath
	wire [63:0] signed_product;
	wire [63:0] unsigned_product;
	wire [63:0] product;
	wire [63:0] pair;
	wire [31:0] quotient;
	wire [31:0] remainder;
	wire [63:0] wide_a_signed;
	wire [63:0] wide_b_signed;
	wire [63:0] wide_a_unsigned;
	wire [63:0] wide_b_unsigned;
	wire signed [31:0] signed_quotient;
	wire signed [31:0] signed_remainder;
	wire div_by_zero;
	reg [31:0] next_high;
	reg [31:0] next_low;

	operand_select select_a (
		.mode(READ_A_MODE),
		.full_index(READ_A_INDEX),
		.compact_code(READ_A_CODE),
		.reg_num(read_a_num),
		.use_pc(read_a_pc)
	);

	operand_select select_b (
		.mode(READ_B_MODE),
		.full_index(READ_B_INDEX),
		.compact_code(READ_B_CODE),
		.reg_num(read_b_num),
		.use_pc(read_b_pc)
	);

	operand_select select_w (
		.mode(WRITE_MODE),
		.full_index(WRITE_INDEX),
		.compact_code(WRITE_CODE),
		.reg_num(write_num_sel),
		.use_pc(write_pc)
	);

	// return mode doubles as the implicit link destination
	assign write_num = write_num_sel; // [RULE_03]
	// pc is never a write target; register zero discards writes
	assign write_ok = WRITE_EN && !write_pc && (write_num != `ZERO_REG); // [RULE_02] [RULE_09]

	// one write per clock, contents not reset
	always @(posedge CLK) begin
		if (write_ok) begin
			general_reg[write_num] <= WRITE_DATA; // [RULE_01] [RULE_15]
		end
	end

	// two reads per clock with same-cycle write bypass
	always @* begin
		if (read_a_pc) begin
			next_read_a = PC_VALUE; // [RULE_13]
		end else if (read_a_num == `ZERO_REG) begin
			next_read_a = `RESET_WORD; // [RULE_02]
		end else if (write_ok && (write_num == read_a_num)) begin
			next_read_a = WRITE_DATA; // [RULE_14]
		end else begin
			next_read_a = general_reg[read_a_num]; // [RULE_01]
		end
	end

	// port b resolves its operand the same way
	always @* begin
		if (read_b_pc) begin
			next_read_b = PC_VALUE; // [RULE_13]
		end else if (read_b_num == `ZERO_REG) begin
			next_read_b = `RESET_WORD; // [RULE_02]
		end else if (write_ok && (write_num == read_b_num)) begin
			next_read_b = WRITE_DATA; // [RULE_14]
		end else begin
			next_read_b = general_reg[read_b_num]; // [RULE_01]
		end
	end

	// operands widened on purpose so the product keeps all 64 bits
	assign wide_a_signed = {{32{MDU_A[31]}}, MDU_A};
	assign wide_b_signed = {{32{MDU_B[31]}}, MDU_B};
	assign wide_a_unsigned = {32'h00000000, MDU_A};
	assign wide_b_unsigned = {32'h00000000, MDU_B};
	assign signed_product = wide_a_signed * wide_b_signed;
	assign unsigned_product = wide_a_unsigned * wide_b_unsigned;
	assign product = MDU_UNSIGNED ? unsigned_product : signed_product;
	assign pair = {RESULT_HIGH_WORD, RESULT_LOW_WORD};
	// signed divide kept apart: an unsigned arm in one expression makes it unsigned
	assign signed_quotient = $signed(MDU_A) / $signed(MDU_B);
	assign signed_remainder = $signed(MDU_A) % $signed(MDU_B);
	assign quotient = MDU_UNSIGNED ? (MDU_A / MDU_B) : signed_quotient;
	assign remainder = MDU_UNSIGNED ? (MDU_A % MDU_B) : signed_remainder;
	assign div_by_zero = (MDU_B == `RESET_WORD);

	always @* begin
		next_high = RESULT_HIGH_WORD;
		next_low = RESULT_LOW_WORD;
		case (MDU_OP)
			`MDU_MUL: begin
				next_high = product[63:32]; // [RULE_04] [RULE_05]
				next_low = product[31:0]; // [RULE_05]
			end
			`MDU_DIV: begin
				// divide by zero leaves the pair unchanged
				if (!div_by_zero) begin
					next_low = quotient; // [RULE_06]
					next_high = remainder; // [RULE_06]
				end
			end
			`MDU_MADD: begin
				{next_high, next_low} = pair + product; // [RULE_07] [RULE_08]
			end
			`MDU_MSUB: begin
				{next_high, next_low} = pair - product; // [RULE_07] [RULE_08]
			end
			`MDU_SET_HIGH: begin
				next_high = MDU_A; // [RULE_04]
			end
			`MDU_SET_LOW: begin
				next_low = MDU_A; // [RULE_04]
			end
			default: begin
				next_high = RESULT_HIGH_WORD;
				next_low = RESULT_LOW_WORD;
			end
		endcase
	end

	// decoded instruction fields, one cycle after the word
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			OPCODE <= 6'h00;
			FIRST_SOURCE_FIELD <= 5'h00;
			SECOND_SOURCE_FIELD <= 5'h00;
			DEST_FIELD <= 5'h00;
			SHIFT_AMOUNT_FIELD <= 5'h00;
			FUNCTION_FIELD <= 6'h00;
		end else begin
			OPCODE <= INSTR_WORD[`OPCODE_HI:`OPCODE_LO]; // [RULE_10]
			FIRST_SOURCE_FIELD <= INSTR_WORD[`FIRST_SRC_HI:`FIRST_SRC_LO]; // [RULE_10]
			SECOND_SOURCE_FIELD <= INSTR_WORD[`SECOND_SRC_HI:`SECOND_SRC_LO]; // [RULE_10]
			DEST_FIELD <= INSTR_WORD[`DEST_HI:`DEST_LO]; // [RULE_10]
			SHIFT_AMOUNT_FIELD <= INSTR_WORD[`SHAMT_HI:`SHAMT_LO]; // [RULE_10]
			FUNCTION_FIELD <= INSTR_WORD[`FUNCT_HI:`FUNCT_LO]; // [RULE_10]
		end
	end

	// registered read data
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			READ_A_DATA <= `RESET_WORD;
			READ_B_DATA <= `RESET_WORD;
		end else begin
			READ_A_DATA <= next_read_a;
			READ_B_DATA <= next_read_b;
		end
	end

	// result word pair; reset to zero so the outputs start defined
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			RESULT_HIGH_WORD <= `RESET_WORD;
			RESULT_LOW_WORD <= `RESET_WORD;
		end else begin
			RESULT_HIGH_WORD <= next_high; // [RULE_08]
			RESULT_LOW_WORD <= next_low;
		end
	end
endmodule
`default_nettype wire

// [tb/regfile_checker_properties.sv]
// assertions on register file ports
`timescale 1ns/10ps
`default_nettype none
module regfile_checker (
	// observed ports
	input wire logic CLK, RST_N, WRITE_EN, MDU_UNSIGNED,
	input wire logic [31:0] INSTR_WORD, PC_VALUE, READ_A_DATA, WRITE_DATA, MDU_A, MDU_B,
	input wire logic [31:0] RESULT_HIGH_WORD, RESULT_LOW_WORD,
	input wire logic [5:0] OPCODE,
	input wire logic [4:0] DEST_FIELD, READ_A_INDEX, WRITE_INDEX,
	input wire logic [2:0] READ_A_MODE, WRITE_MODE, MDU_OP
);
	wire [63:0] pair = {RESULT_HIGH_WORD, RESULT_LOW_WORD};
	wire [63:0] prod = {32'h0, MDU_A} * {32'h0, MDU_B};
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	chk_field_decode: assert property ($past(RST_N) |->
		{OPCODE, DEST_FIELD} == {$past(INSTR_WORD[31:26]), $past(INSTR_WORD[15:11])})
		else $error("field decode wrong");
	chk_zero_read: assert property ($past(RST_N && READ_A_MODE == 3'h0 && READ_A_INDEX == 5'h0)
		|-> READ_A_DATA == 32'h0) else $error("register zero not zero");
	chk_write_bypass: assert property ($past(RST_N && WRITE_EN && WRITE_MODE == 3'h0 &&
		WRITE_INDEX != 5'h0 && READ_A_MODE == 3'h0 && READ_A_INDEX == WRITE_INDEX)
		|-> READ_A_DATA == $past(WRITE_DATA)) else $error("bypass wrong");
	chk_link_write: assert property ($past(RST_N && WRITE_EN && WRITE_MODE == 3'h4 &&
		READ_A_MODE == 3'h4) |-> READ_A_DATA == $past(WRITE_DATA)) else $error("link write wrong");
	chk_pc_operand: assert property ($past(RST_N && READ_A_MODE == 3'h5)
		|-> READ_A_DATA == $past(PC_VALUE)) else $error("pc operand wrong");
	chk_mul_product: assert property (MDU_OP == 3'h1 && MDU_UNSIGNED
		|=> pair == $past(prod)) else $error("product wrong");
	chk_div_split: assert property (MDU_OP == 3'h2 && MDU_UNSIGNED && MDU_B != 32'h0
		|=> RESULT_LOW_WORD == $past(MDU_A) / $past(MDU_B)
		&& RESULT_HIGH_WORD == $past(MDU_A) % $past(MDU_B)) else $error("divide wrong");
	chk_madd_acc: assert property (MDU_OP == 3'h3 && MDU_UNSIGNED
		|=> pair == $past(pair) + $past(prod)) else $error("accumulate wrong");
	chk_pair_hold: assert property (MDU_OP == 3'h0 |=> $stable(pair))
		else $error("pair changed while idle");
	cover property (MDU_OP == 3'h3 && MDU_UNSIGNED);
	cover property (WRITE_EN && WRITE_MODE == 3'h4 && READ_A_MODE == 3'h4);
	cover property (READ_A_MODE == 3'h5);
endmodule
bind cpu_gpr_hilo_register_file regfile_checker chk (.*);
`default_nettype wire

// [tb/fetch_model.sv]
// fetch stage model: program counter and instruction words
`timescale 1ns/10ps
`default_nettype none
module fetch_model (
	// clock, reset and fetched word
	input wire logic clk, rst_n,
	output logic [31:0] pc, instr
);
	always @(negedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc <= 32'h0;
			instr <= 32'h1234abcd;
		end else begin
			pc <= pc + 32'h4;
			instr <= instr * 32'h0019660d + 32'h3c6ef35f;
		end
	end
endmodule
`default_nettype wire

// [tb/cpu_gpr_hilo_register_file_tb_top.sv]
// self-checking bench for the register file
`timescale 1ns/10ps
`default_nettype none
module cpu_gpr_hilo_register_file_tb_top;
	logic CLK = 0, RST_N = 0, WRITE_EN = 0, MDU_UNSIGNED = 0;
	logic [31:0] INSTR_WORD, PC_VALUE, READ_A_DATA, READ_B_DATA, RESULT_HIGH_WORD, RESULT_LOW_WORD;
	logic [31:0] WRITE_DATA = 0, MDU_A = 0, MDU_B = 0;
	logic [2:0] READ_A_MODE = 0, READ_B_MODE = 0, READ_A_CODE = 0, READ_B_CODE = 0;
	logic [2:0] WRITE_MODE = 0, WRITE_CODE = 0, MDU_OP = 0;
	logic [4:0] READ_A_INDEX = 0, READ_B_INDEX = 0, WRITE_INDEX = 0;
	logic [4:0] FIRST_SOURCE_FIELD, SECOND_SOURCE_FIELD, DEST_FIELD, SHIFT_AMOUNT_FIELD;
	logic [5:0] OPCODE, FUNCTION_FIELD;
	int n_fail = 0, checks = 0;
	cpu_gpr_hilo_register_file DUT (.*);
	fetch_model far (.clk(CLK), .rst_n(RST_N), .pc(PC_VALUE), .instr(INSTR_WORD));
	always #10 CLK = ~CLK;
	function automatic logic [31:0] val(int i);
		return {8'ha5, 8'(i), 8'h3c, 8'(~i)};
	endfunction
	task automatic chk(string what, logic [63:0] exp, got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd(logic [2:0] ma, mb, ca, logic [4:0] ia, ib);
		@(negedge CLK);
		{READ_A_MODE, READ_B_MODE, READ_A_CODE, READ_A_INDEX, READ_B_INDEX} = {ma, mb, ca, ia, ib};
		@(negedge CLK);
	endtask
	task automatic t_decode;
		logic [31:0] w;
		repeat (8) begin
			@(posedge CLK);
			w = INSTR_WORD;
			@(negedge CLK);
			chk("fields", w, {OPCODE, FIRST_SOURCE_FIELD, SECOND_SOURCE_FIELD, DEST_FIELD,
				SHIFT_AMOUNT_FIELD, FUNCTION_FIELD});
		end
	endtask
	task automatic t_regs;
		for (int i = 0; i < 33; i++) begin
			@(negedge CLK);
			if (i > 0) chk("bypass", i > 1 ? val(i - 1) : 0, READ_A_DATA);
			{WRITE_EN, WRITE_MODE, WRITE_INDEX, WRITE_DATA} = {i < 32, 3'h0, 5'(i), val(i)};
			{READ_A_MODE, READ_A_INDEX} = {3'h0, 5'(i)};
		end
		for (int i = 0; i < 32; i++) begin
			rd(3'h0, 3'h0, 3'h0, 5'h0, 5'(i));
			chk("stored", i ? val(i) : 0, READ_B_DATA);
		end
	endtask
	task automatic t_compact;
		logic [31:0] d;
		for (int c = 0; c < 8; c++) begin
			rd(3'h1, 3'(2 + c % 3), 3'(c), 5'h0, 5'h0);
			chk("compact", val(c < 2 ? 16 + c : c), READ_A_DATA);
			chk("implicit", val(c % 3 == 0 ? 24 : c % 3 == 1 ? 29 : 31), READ_B_DATA);
		end
		for (int c = 0; c < 8; c++) begin
			d = ~val(c);
			@(negedge CLK);
			{WRITE_EN, WRITE_MODE, WRITE_CODE, WRITE_DATA} = {1'b1, 3'h1, 3'(c), d};
			@(negedge CLK);
			{WRITE_EN, READ_B_CODE} = {1'b0, 3'(c)};
			rd(3'h0, 3'h1, 3'h0, 5'(c < 2 ? 16 + c : c), 5'h0);
			chk("compact write", d, READ_A_DATA);
			chk("compact read b", d, READ_B_DATA);
		end
		@(negedge CLK);
		{WRITE_EN, WRITE_MODE, WRITE_DATA} = {1'b1, 3'h2, 32'hc0de0024};
		@(negedge CLK);
		WRITE_EN = 0;
		rd(3'h6, 3'h0, 3'h0, 5'd24, 5'h0);
		chk("cond write", 32'hc0de0024, READ_A_DATA);
	endtask
	task automatic t_link;
		@(negedge CLK);
		{WRITE_EN, WRITE_MODE, WRITE_DATA, READ_A_MODE} = {1'b1, 3'h4, 32'hc0de0031, 3'h4};
		@(negedge CLK);
		chk("link", 32'hc0de0031, READ_A_DATA);
		{WRITE_MODE, WRITE_INDEX, WRITE_DATA} = {3'h5, 5'h1f, 32'hdead0005};
		rd(3'h5, 3'h0, 3'h0, 5'h0, 5'h1f);
		WRITE_EN = 0;
		chk("pc operand", PC_VALUE, READ_A_DATA);
		chk("pc write", 32'hc0de0031, READ_B_DATA);
	endtask
	task automatic mdu(logic [2:0] op, logic u, logic [31:0] a, b, logic [63:0] exp);
		{MDU_OP, MDU_UNSIGNED, MDU_A, MDU_B} = {op, u, a, b};
		@(negedge CLK);
		chk("result pair", exp, {RESULT_HIGH_WORD, RESULT_LOW_WORD});
	endtask
	task automatic t_mdu;
		mdu(3'h1, 0, 32'hfffffffd, 32'h5, 64'hffffffff_fffffff1);
		mdu(3'h3, 1, 32'h2, 32'h3, 64'hffffffff_fffffff7);
		mdu(3'h4, 0, 32'hffffffff, 32'h8, 64'hffffffff_ffffffff);
		mdu(3'h2, 0, 32'hfffffff9, 32'h2, 64'hffffffff_fffffffd);
		mdu(3'h2, 1, 32'h64, 32'h0, 64'hffffffff_fffffffd);
		mdu(3'h2, 1, 32'h64, 32'h7, 64'h00000002_0000000e);
		mdu(3'h5, 0, 32'h89abcdef, 32'h0, 64'h89abcdef_0000000e);
		mdu(3'h6, 0, 32'h01234567, 32'h0, 64'h89abcdef_01234567);
		mdu(3'h1, 1, 32'hffffffff, 32'hffffffff, 64'hfffffffe_00000001);
		mdu(3'h0, 0, 32'h1, 32'h1, 64'hfffffffe_00000001);
		mdu(3'h7, 1, 32'h5, 32'h5, 64'hfffffffe_00000001);
	endtask
	task automatic give_verdict;
		if (n_fail == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge CLK);
		RST_N = 1;
		t_decode;
		t_regs;
		t_compact;
		t_link;
		t_mdu;
		give_verdict;
	end
endmodule
`default_nettype wire
